/* logic/cfse_defines.vh */
// Register map, field positions, reset values and counter steps of the CAN status block
`ifndef CFSE_DEFINES_VH
`define CFSE_DEFINES_VH

// ----------------------------------------
// Register byte offsets; the FIFO windows are codes of address bits 6:5
// ----------------------------------------
`define CFSE_OFS_CONTROL 7'h00
`define CFSE_OFS_ERR_FLAGS 7'h04
`define CFSE_OFS_ERR_COUNTS 7'h08
`define CFSE_OFS_IRQ_STATUS 7'h0C
`define CFSE_OFS_IRQ_ENABLE 7'h10
`define CFSE_OFS_IRQ_CLEAR 7'h14
`define CFSE_OFS_TX_REQUEST 7'h18
`define CFSE_OFS_FIFO_CFG 2'h1
`define CFSE_OFS_FIFO_STAT 2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFSE_CFG_DIR_BIT 7
`define CFSE_STAT_ABORT_BIT 3
`define CFSE_STAT_IDX_LSB 8
`define CFSE_IRQ_WARN_BIT 0
`define CFSE_IRQ_PASSIVE_BIT 1
`define CFSE_IRQ_BUS_OFF_BIT 2
`define CFSE_IRQ_ABORT_BIT 3
`define CFSE_CFG_DEPTH_LSB 0
`define CFSE_STAT_EF_BIT 2
`define CFSE_STAT_HALF_BIT 1
`define CFSE_STAT_SD_BIT 0
`define CFSE_FLAG_ANY_WARN_BIT 0
`define CFSE_FLAG_RX_WARN_BIT 1
`define CFSE_FLAG_TX_WARN_BIT 2
`define CFSE_FLAG_RX_PASSIVE_BIT 3
`define CFSE_FLAG_TX_PASSIVE_BIT 4
`define CFSE_FLAG_BUS_OFF_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CFSE_RST_CONFIG_MODE 1'h1
`define CFSE_RST_DEPTH 5'h03
`define CFSE_RST_DIR 1'h0
`define CFSE_RST_BUS_OFF 1'h1

// ----------------------------------------
// Fault confinement thresholds and steps
// ----------------------------------------
`define CFSE_WARN_LOW 9'h05F
`define CFSE_PASSIVE_LOW 9'h07F
`define CFSE_BUS_OFF_LOW 9'h0FF
`define CFSE_ERR_STEP_MAJOR 9'h008
`define CFSE_REC_PASSIVE_RELOAD 8'h78
`define CFSE_REC_SAT_LIMIT 8'hF7

`endif

/* logic/cfse_top.v */
// CAN FIFO status flags, message index and fault confinement status with Avalon-MM registers
`timescale 1ns/100ps
`include "cfse_defines.vh"

module cfse_top (
	input wire clk,
	input wire rst_n,
	input wire [6:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [6:0] fifo_push,
	input wire [6:0] fifo_pop,
	input wire [6:0] fifo_msg_done,
	input wire [6:0] fifo_msg_abort,
	input wire [6:0] fifo_reset,
	input wire transmit_queue_reset,
	input wire tx_error,
	input wire tx_success,
	input wire rx_error,
	input wire rx_error_major,
	input wire rx_success,
	input wire bus_off_recovered,
	output reg irq,
	output reg tx_bus_off
);

// ----------------------------------------
// Bus slave
// ----------------------------------------
wire rd_cap;
wire wr_acc;
wire [2:0] sel;
wire cfg_hit;
wire stat_hit;
reg [31:0] rd_mux;
reg config_mode;
reg [3:0] irq_status;
reg [3:0] irq_enable;
reg [8:0] tec;
reg [7:0] rec;
wire [7:0] tec_view;
reg [5:0] err_flags;
wire [111:0] fifo_stat_all;
wire [55:0] fifo_cfg_all;
wire [6:0] abort_any;

// Read data is captured one edge before the accepting edge so it stands there
assign rd_cap = avs_read & avs_waitrequest;
assign wr_acc = avs_write & ~avs_waitrequest & avs_byteenable[0];
assign sel = avs_address[4:2];
assign cfg_hit = (avs_address[6:5] == `CFSE_OFS_FIFO_CFG) && (sel != 3'h7);
assign stat_hit = (avs_address[6:5] == `CFSE_OFS_FIFO_STAT) && (sel != 3'h7);

// Exactly one wait state per access, whatever the address
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		avs_waitrequest <= 1'b1;
	end else begin
		avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
	end
end

always @* begin
	rd_mux = 32'h00000000;
	if (avs_address == `CFSE_OFS_CONTROL) begin
		rd_mux[0] = config_mode;
	end else if (avs_address == `CFSE_OFS_ERR_FLAGS) begin
		rd_mux[5:0] = err_flags;
	end else if (avs_address == `CFSE_OFS_ERR_COUNTS) begin
		rd_mux[15:8] = tec_view;
		rd_mux[7:0] = rec;
	end else if (avs_address == `CFSE_OFS_IRQ_STATUS) begin
		rd_mux[3:0] = irq_status;
	end else if (avs_address == `CFSE_OFS_IRQ_ENABLE) begin
		rd_mux[3:0] = irq_enable;
	end else if (cfg_hit) begin
		rd_mux[7:0] = fifo_cfg_all[8*sel +: 8];
	end else if (stat_hit) begin
		rd_mux[15:0] = fifo_stat_all[16*sel +: 16];
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		avs_readdata <= 32'h00000000;
	end else if (rd_cap) begin
		avs_readdata <= rd_mux;
	end
end

// ----------------------------------------
// Write decode
// ----------------------------------------
reg wr_control;
reg wr_irq_enable;
reg wr_irq_clear;
reg wr_tx_request;
reg wr_fifo_cfg;

// Read-only and unmapped offsets match no branch, so writes there are dropped
always @* begin
	wr_control = 1'b0;
	wr_irq_enable = 1'b0;
	wr_irq_clear = 1'b0;
	wr_tx_request = 1'b0;
	wr_fifo_cfg = 1'b0;
	if (wr_acc) begin
		if (avs_address == `CFSE_OFS_CONTROL) begin
			wr_control = 1'b1;
		end else if (avs_address == `CFSE_OFS_IRQ_ENABLE) begin
			wr_irq_enable = 1'b1;
		end else if (avs_address == `CFSE_OFS_IRQ_CLEAR) begin
			wr_irq_clear = 1'b1;
		end else if (avs_address == `CFSE_OFS_TX_REQUEST) begin
			wr_tx_request = 1'b1;
		end else if (cfg_hit) begin
			wr_fifo_cfg = 1'b1;
		end
	end
end

// ----------------------------------------
// Control register
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		config_mode <= `CFSE_RST_CONFIG_MODE;
	end else if (wr_control) begin
		config_mode <= avs_writedata[0];
	end
end

// ----------------------------------------
// Per FIFO status
// ----------------------------------------
genvar g;
generate
	for (g = 0; g < 7; g = g + 1) begin : fifo_g
		localparam [2:0] slot_sel = g;
		reg [4:0] depth;
		reg dir;
		reg [5:0] occ;
		reg [4:0] idx;
		reg abort_flag;
		wire [5:0] cap;
		wire [6:0] occ2;
		wire [6:0] cap2;
		wire empty;
		wire full;
		wire flag_ef;
		wire flag_half;
		wire flag_sd;
		wire cfg_wr;
		wire stat_rd;
		wire abort_clr;
		reg [7:0] cfg_word;
		reg [15:0] stat_word;

		assign cap = {1'b0, depth} + 6'h01;
		assign occ2 = {occ, 1'b0};
		assign cap2 = {1'b0, cap};
		assign empty = (occ == 6'h00);
		assign full = (occ >= cap);
		assign flag_ef = dir ? empty : full;
		assign flag_half = dir ? (occ2 <= cap2) : (occ2 >= cap2);
		assign flag_sd = dir ? ~full : ~empty;
		assign cfg_wr = wr_fifo_cfg && (sel == slot_sel);
		assign stat_rd = rd_cap && stat_hit && (sel == slot_sel);
		assign abort_clr = stat_rd | transmit_queue_reset |
			(wr_tx_request && avs_writedata[g]);
		assign fifo_cfg_all[8*g +: 8] = cfg_word;
		assign fifo_stat_all[16*g +: 16] = stat_word;
		assign abort_any[g] = fifo_msg_abort[g];

		always @* begin
			cfg_word = 8'h00;
			cfg_word[`CFSE_CFG_DEPTH_LSB +: 5] = depth;
			cfg_word[`CFSE_CFG_DIR_BIT] = dir;
		end

		// Unused status bits stay zero
		always @* begin
			stat_word = 16'h0000;
			stat_word[`CFSE_STAT_IDX_LSB +: 5] = idx;
			stat_word[`CFSE_STAT_ABORT_BIT] = abort_flag;
			stat_word[`CFSE_STAT_EF_BIT] = flag_ef;
			stat_word[`CFSE_STAT_HALF_BIT] = flag_half;
			stat_word[`CFSE_STAT_SD_BIT] = flag_sd;
		end

		always @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				depth <= `CFSE_RST_DEPTH;
				dir <= `CFSE_RST_DIR;
			end else if (cfg_wr) begin
				depth <= avs_writedata[`CFSE_CFG_DEPTH_LSB +: 5];
				dir <= avs_writedata[`CFSE_CFG_DIR_BIT];
			end
		end

		// Occupancy saturates so a stray push or pop never wraps the flags
		always @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				occ <= 6'h00;
			end else if (fifo_reset[g]) begin
				occ <= 6'h00;
			end else if (fifo_push[g] && !full && !(fifo_pop[g] && !empty)) begin
				occ <= occ + 6'h01;
			end else if (fifo_pop[g] && !empty && !(fifo_push[g] && !full)) begin
				occ <= occ - 6'h01;
			end else if (occ > cap) begin
				occ <= cap;
			end
		end

		always @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				idx <= 5'h00;
			end else if (fifo_reset[g]) begin
				idx <= 5'h00;
			end else if (fifo_msg_done[g] || fifo_msg_abort[g]) begin
				idx <= (idx >= depth) ? 5'h00 : idx + 5'h01;
			end
		end

		// A new abort wins over a clear in the same cycle
		always @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				abort_flag <= 1'b0;
			end else if (fifo_msg_abort[g]) begin
				abort_flag <= 1'b1;
			end else if (abort_clr) begin
				abort_flag <= 1'b0;
			end
		end
	end
endgenerate

// ----------------------------------------
// Fault confinement counters
// ----------------------------------------
wire tx_warn;
wire rx_warn;
wire tx_passive;
wire rx_passive;
wire boff;

assign boff = (tec > `CFSE_BUS_OFF_LOW) | config_mode;
assign tx_passive = (tec > `CFSE_PASSIVE_LOW);
assign rx_passive = ({1'b0, rec} > `CFSE_PASSIVE_LOW);
assign tx_warn = (tec > `CFSE_WARN_LOW) && !tx_passive;
assign rx_warn = ({1'b0, rec} > `CFSE_WARN_LOW) && !rx_passive;
// The view is one byte, so a bus-off count shows as all ones
assign tec_view = tec[8] ? 8'hFF : tec[7:0];

always @* begin
	err_flags = 6'h00;
	err_flags[`CFSE_FLAG_BUS_OFF_BIT] = boff;
	err_flags[`CFSE_FLAG_TX_PASSIVE_BIT] = tx_passive;
	err_flags[`CFSE_FLAG_RX_PASSIVE_BIT] = rx_passive;
	err_flags[`CFSE_FLAG_TX_WARN_BIT] = tx_warn;
	err_flags[`CFSE_FLAG_RX_WARN_BIT] = rx_warn;
	err_flags[`CFSE_FLAG_ANY_WARN_BIT] = tx_warn | rx_warn;
end

// The transmit counter freezes once bus-off; only the recovery sequence or config mode clears both counters
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		tec <= 9'h000;
	end else if (config_mode || bus_off_recovered) begin
		tec <= 9'h000;
	end else if (tec > `CFSE_BUS_OFF_LOW) begin
		tec <= tec;
	end else if (tx_error) begin
		tec <= tec + `CFSE_ERR_STEP_MAJOR;
	end else if (tx_success && tec != 9'h000) begin
		tec <= tec - 9'h001;
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		rec <= 8'h00;
	end else if (config_mode || bus_off_recovered) begin
		rec <= 8'h00;
	end else if (rx_error_major) begin
		rec <= (rec > `CFSE_REC_SAT_LIMIT) ? 8'hFF : rec + 8'h08;
	end else if (rx_error) begin
		rec <= (rec == 8'hFF) ? 8'hFF : rec + 8'h01;
	end else if (rx_success && rx_passive) begin
		rec <= `CFSE_REC_PASSIVE_RELOAD;
	end else if (rx_success && rec != 8'h00) begin
		rec <= rec - 8'h01;
	end
end

// ----------------------------------------
// Interrupts
// ----------------------------------------
reg prev_warn;
reg prev_passive;
reg prev_boff;
wire [3:0] irq_event;
wire [3:0] irq_clr;

assign irq_event[`CFSE_IRQ_WARN_BIT] = err_flags[`CFSE_FLAG_ANY_WARN_BIT] & ~prev_warn;
assign irq_event[`CFSE_IRQ_PASSIVE_BIT] = (tx_passive | rx_passive) & ~prev_passive;
assign irq_event[`CFSE_IRQ_BUS_OFF_BIT] = boff & ~prev_boff;
assign irq_event[`CFSE_IRQ_ABORT_BIT] = |abort_any;
assign irq_clr = wr_irq_clear ? avs_writedata[3:0] : 4'h0;

// Bus-off history starts set so leaving reset in config mode raises no event
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		prev_warn <= 1'b0;
		prev_passive <= 1'b0;
		prev_boff <= `CFSE_RST_BUS_OFF;
	end else begin
		prev_warn <= err_flags[`CFSE_FLAG_ANY_WARN_BIT];
		prev_passive <= tx_passive | rx_passive;
		prev_boff <= boff;
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		irq_status <= 4'h0;
	end else begin
		irq_status <= irq_event | (irq_status & ~irq_clr);
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		irq_enable <= 4'h0;
	end else if (wr_irq_enable) begin
		irq_enable <= avs_writedata[3:0];
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		irq <= 1'b0;
		tx_bus_off <= `CFSE_RST_BUS_OFF;
	end else begin
		irq <= |(irq_status & irq_enable);
		tx_bus_off <= boff;
	end
end

endmodule

/* sim/cfse_checker.sv */
// Port assertions for the CAN status block
`timescale 1ns/100ps
module cfse_checker (
	input wire clk,
	input wire rst_n,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire tx_error,
	input wire tx_success,
	input wire rx_error,
	input wire rx_error_major,
	input wire rx_success,
	input wire [6:0] fifo_msg_abort,
	input wire bus_off_recovered,
	input wire irq,
	input wire tx_bus_off
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire wr_done = avs_write && !avs_waitrequest;
	reg [3:0] evq;
	// Counter-driven status lags its event by two cycles, so keep a short event history
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evq <= 4'h0;
		end else begin
			evq <= {evq[2:0], tx_error | tx_success | rx_error | rx_error_major | rx_success |
				(|fifo_msg_abort) | wr_done};
		end
	end
	property p_wt_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
	a_wt_one: assert property (p_wt_one) else $error("wait low too long");
	property p_wt_req; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
	a_wt_req: assert property (p_wt_req) else $error("answer without request");
	property p_wt_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wt_ans: assert property (p_wt_ans) else $error("request not answered");
	property p_wt_idle; !avs_read && !avs_write && $past(!avs_read && !avs_write)
		|-> avs_waitrequest; endproperty
	a_wt_idle: assert property (p_wt_idle) else $error("wait low while idle");
	property p_bo_rise; $rose(tx_bus_off) |-> $past(tx_error, 2) || $past(wr_done, 2); endproperty
	a_bo_rise: assert property (p_bo_rise) else $error("bus-off without cause");
	property p_bo_fall; $fell(tx_bus_off) |-> $past(wr_done, 2) || $past(bus_off_recovered, 2);
	endproperty
	a_bo_fall: assert property (p_bo_fall) else $error("bus-off dropped");
	property p_irq_rise; $rose(irq) |-> |evq; endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without event");
	property p_irq_fall; $fell(irq) |-> $past(wr_done, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
	c_bo: cover property ($rose(tx_bus_off));
	c_irq: cover property ($fell(irq));
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule

/* sim/cfse_can_node.sv */
// Other bus nodes: bursts of error and success events
`timescale 1ns/100ps
module cfse_can_node (
	input wire clk,
	input wire go,
	input wire [2:0] kind,
	input wire [5:0] num,
	input wire slow,
	output reg [4:0] ev,
	output wire busy
);
	reg [6:0] left = 7'h00;
	reg gap = 1'b0;
	assign busy = left != 7'h00;
	always @(posedge clk) begin
		ev <= 5'h00;
		gap <= slow & ~gap;
		if (go) begin
			left <= {1'b0, num};
		end else if (busy && !gap) begin
			ev <= 5'h01 << kind;
			left <= left - 7'h01;
		end
	end
endmodule

/* sim/can_fifo_status_error_state_tb.sv */
// Self-checking bench of the CAN status block
`timescale 1ns/100ps
`include "cfse_defines.vh"
module can_fifo_status_error_state_tb;
	reg clk = 0, rst_n = 0, rd = 0, wr = 0, go = 0, slow = 0, bor = 0, tqr = 0;
	reg [6:0] adr = 0, push = 0, pop = 0, done = 0, abt = 0, frst = 0;
	reg [31:0] wd = 0, d;
	reg [2:0] kind = 0;
	reg [5:0] num = 0;
	reg [8:0] st;
	reg [8:0] hand [0:6] = '{9'h00C, 9'h0A1, 9'h004, 9'h0D0, 9'h101, 9'h0A4, 9'h010};
	wire [31:0] rdata;
	wire [4:0] ev;
	wire wt, irq, bo, busy;
	integer err_total = 0, tests_run = 0, cyc = 0, i, n, tec = 0, rec = 0;
	cfse_top uut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wt),
		.fifo_push(push), .fifo_pop(pop), .fifo_msg_done(done), .fifo_msg_abort(abt),
		.fifo_reset(frst), .transmit_queue_reset(tqr), .tx_error(ev[0]), .tx_success(ev[1]),
		.rx_error(ev[2]), .rx_error_major(ev[3]), .rx_success(ev[4]),
		.bus_off_recovered(bor), .irq(irq), .tx_bus_off(bo));
	cfse_can_node node (.clk(clk), .go(go), .kind(kind), .num(num), .slow(slow), .ev(ev),
		.busy(busy));
	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task chk(input [31:0] g, input [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("ERROR %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task bus(input w, input [6:0] a, input [31:0] v);
		begin
			adr <= a;
			wd <= v;
			rd <= !w;
			wr <= w;
			do @(posedge clk); while (wt !== 1'b0);
			d = rdata;
			rd <= 0;
			wr <= 0;
			@(posedge clk);
		end
	endtask
	task rdchk(input [6:0] a, input [31:0] e);
		begin
			bus(0, a, 0);
			chk(d, e);
		end
	endtask
	task irqchk(input e);
		begin
			@(negedge clk);
			chk(irq, e);
			@(posedge clk);
		end
	endtask
	task fev(input [2:0] k);
		begin
			{tqr, frst[0], abt[0], done[0], pop[0], push[0]} <= 6'h01 << k;
			@(posedge clk);
			{tqr, frst[0], abt[0], done[0], pop[0], push[0]} <= 6'h00;
		end
	endtask
	function [31:0] eflags(input integer t, input integer r);
		reg tw, rw;
		begin
			tw = t > 95 && t < 128;
			rw = r > 95 && r < 128;
			eflags = {t > 255, t > 127, r > 127, tw, rw, tw | rw};
		end
	endfunction
	function [31:0] efifo(input tx, input integer o, input integer x, input ab);
		efifo = {x[4:0], 4'h0, ab, tx ? o == 0 : o == 4, tx ? 2 * o <= 4 : 2 * o >= 4,
			tx ? o < 4 : o > 0};
	endfunction
	task end_sim;
		begin
			if (err_total == 0 && tests_run > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask
	// ----------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end
	initial begin
		n = $urandom(28);
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rdchk(`CFSE_OFS_ERR_FLAGS, 32'h20);
		rdchk(`CFSE_OFS_ERR_COUNTS, 0);
		rdchk(7'h7C, 0);
		bus(1, `CFSE_OFS_ERR_FLAGS, 32'hFFFF);
		rdchk(`CFSE_OFS_ERR_FLAGS, 32'h20);
		bus(1, `CFSE_OFS_CONTROL, 0);
		rdchk(`CFSE_OFS_ERR_FLAGS, 0);
		bus(1, `CFSE_OFS_IRQ_ENABLE, 32'h8);
		for (i = 0; i < 6; i = i + 1) begin
			rdchk(7'h40, efifo(0, i > 4 ? 4 : i, 0, 0));
			fev(0);
		end
		for (i = 0; i < 5; i = i + 1) begin
			rdchk(7'h40, efifo(0, 4, i % 4, 0));
			fev(2);
		end
		bus(1, 7'h20, 32'h83);
		for (i = 0; i < 6; i = i + 1) begin
			rdchk(7'h40, efifo(1, i > 4 ? 0 : 4 - i, 1, 0));
			fev(1);
		end
		fev(3);
		rdchk(7'h40, efifo(1, 0, 2, 1));
		rdchk(7'h40, efifo(1, 0, 2, 0));
		irqchk(1);
		bus(1, `CFSE_OFS_IRQ_CLEAR, 32'hF);
		irqchk(0);
		fev(3);
		bus(1, `CFSE_OFS_TX_REQUEST, 32'h1);
		rdchk(7'h40, efifo(1, 0, 3, 0));
		fev(4);
		rdchk(7'h40, efifo(1, 0, 0, 0));
		fev(3);
		fev(5);
		rdchk(7'h40, efifo(1, 0, 1, 0));
		bus(1, `CFSE_OFS_IRQ_CLEAR, 32'hF);
		// Hand-picked bursts land on each transmit threshold, random ones follow
		for (i = 0; i < 16; i = i + 1) begin
			st = i < 7 ? hand[i] : $urandom % 320;
			kind <= st[8:6];
			num <= st[5:0];
			slow <= $urandom % 2;
			go <= 1;
			@(posedge clk);
			go <= 0;
			@(posedge clk);
			do @(negedge clk); while (busy);
			@(posedge clk);
			for (n = 0; n < st[5:0]; n = n + 1) begin
				case (st[8:6])
					0: tec = tec > 255 ? tec : tec + 8;
					1: tec = tec > 255 || tec == 0 ? tec : tec - 1;
					2: rec = rec > 254 ? 255 : rec + 1;
					3: rec = rec > 247 ? 255 : rec + 8;
					default: rec = rec > 127 ? 120 : rec > 0 ? rec - 1 : 0;
				endcase
			end
			rdchk(`CFSE_OFS_ERR_COUNTS, {tec > 255 ? 8'hFF : tec[7:0], rec[7:0]});
			rdchk(`CFSE_OFS_ERR_FLAGS, eflags(tec, rec));
			chk(bo, tec > 255);
			if (tec > 255) begin
				bor <= 1;
				@(posedge clk);
				bor <= 0;
				tec = 0;
				rec = 0;
			end
		end
		irqchk(0);
		bus(1, `CFSE_OFS_IRQ_ENABLE, 32'hF);
		irqchk(1);
		bus(1, `CFSE_OFS_CONTROL, 1);
		rdchk(`CFSE_OFS_ERR_FLAGS, 32'h20);
		end_sim;
	end
endmodule
bind cfse_top cfse_checker chk_i (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .tx_error(tx_error),
	.tx_success(tx_success), .rx_error(rx_error), .rx_error_major(rx_error_major),
	.rx_success(rx_success), .fifo_msg_abort(fifo_msg_abort),
	.bus_off_recovered(bus_off_recovered), .irq(irq), .tx_bus_off(tx_bus_off));
